// [design/tws_map.vh]
/*
  Register offsets, control bit positions, status codes and bus timing
  for the two-wire master sequencer. Assumes APB byte addressing.
*/
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

`define TWS_ADDR_W        12
`define TWS_OFF_CTRL      12'h000
`define TWS_OFF_STATUS    12'h004
`define TWS_OFF_DATA      12'h008

`define TWS_CR_FLAG       7
`define TWS_CR_ACKEN      6
`define TWS_CR_STA        5
`define TWS_CR_STO        4
`define TWS_CR_WCOL       3
`define TWS_CR_EN         2
`define TWS_CR_IE         0

`define TWS_CTRL_RST      8'h00
`define TWS_DATA_RST      8'hff

`define TWS_ST_START      8'h08
`define TWS_ST_RSTART     8'h10
`define TWS_ST_AW_ACK     8'h18
`define TWS_ST_AW_NACK    8'h20
`define TWS_ST_TX_ACK     8'h28
`define TWS_ST_TX_NACK    8'h30
`define TWS_ST_LOST       8'h38
`define TWS_ST_AR_ACK     8'h40
`define TWS_ST_AR_NACK    8'h48
`define TWS_ST_RX_ACK     8'h50
`define TWS_ST_RX_NACK    8'h58
`define TWS_ST_IDLE       8'hf8

`define TWS_CLK_NS        40
`define TWS_SCL_NS        320
`define TWS_QTR_CYC       ((`TWS_SCL_NS) / (4 * `TWS_CLK_NS))

`endif

// [design/tws_master.v]
/*
  Two-wire bus master sequencer with APB register access: START,
  repeated START, STOP, address and data bytes, receive with acknowledge.
  Assumes open-drain pads outside (oe high pulls the line low) and
  pins asynchronous to pclk.
*/
// Implementation choices: the placing of the registers and the APB interface to the registers.
// Operation
// - Control write with flag, start, enable: wait for free bus, send START.
// - After START, set transfer-done flag and report 0x08.
// - Address direction bit picks master transmit or master receive mode.
// - After read address and ack bit, set flag, report 0x38/0x40/0x48.
// - Received byte is in data register when the flag sets.
// - Flag, stop, enable with start clear: generate STOP.
// - Flag, start, enable with stop clear: repeated START, bus kept.
// - After repeated START report 0x10, then address any slave.
// - Repeated START allows slave and direction change keeping the bus.
// - 0x28 byte sent with ACK; 0x30 byte sent with NOT ACK.
// - In 0x28/0x30, new byte with no requests: send byte, sample ack.
// - In 0x28/0x30, start request alone: repeated START.
// - Stop request alone: send STOP, hardware clears stop request.
// - Start and stop both: STOP, then START, stop request cleared.
// - Arbitration lost in write address or data reports 0x38.
// - In 0x38 without start request: release bus, not addressed.
// - In 0x38 with start request: START once the bus is free.
// - Status codes read with the low three bits as zero.
// - Data write while flag low is dropped and sets write collision.
// - After 0x40/0x50, return ACK if acknowledge enable, else NOT ACK.
`timescale 1ns/1ns
`default_nettype none
`include "tws_map.vh"

module tws_master (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`TWS_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire                   scl_i,
  output wire                   scl_o,
  output wire                   scl_oe,
  input  wire                   sda_i,
  output wire                   sda_o,
  output wire                   sda_oe
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_STA  = 3'd1;
  localparam [2:0] S_HOLD = 3'd2;
  localparam [2:0] S_BIT  = 3'd3;
  localparam [2:0] S_STP  = 3'd4;
  localparam integer QTR_CYC  = `TWS_QTR_CYC;
  localparam [7:0]   QTR_LAST = QTR_CYC[7:0] - 8'h01;

  reg  [1:0] scl_sync_r;
  reg  [1:0] sda_sync_r;
  reg  [7:0] div_r;
  reg  [7:0] data_r;
  reg  [7:0] code_r;
  reg  [7:0] sh_r;
  reg  [2:0] st_r;
  reg  [1:0] ph_r;
  reg  [3:0] bit_r;
  reg        sda_prev_r, busy_r, flag_r, acken_r, sta_r, sto_r;
  reg        wcol_r, en_r, ie_r, rx_r, addr_r, rnw_r;
  reg        ack_out_r, ack_in_r, owner_r, scl_drv_r, sda_drv_r;

  wire       scl_s, sda_s, tick, acc, go, last_bit, tx_state, rx_state;
  wire       hit_ctrl, hit_stat, hit_data, wr_ctrl, wr_data;
  wire [7:0] ctrl_rd;

  assign scl_s    = scl_sync_r[1];
  assign sda_s    = sda_sync_r[1];
  assign tick     = (div_r == QTR_LAST);
  assign acc      = psel & penable;
  assign hit_ctrl = (paddr == `TWS_OFF_CTRL);
  assign hit_stat = (paddr == `TWS_OFF_STATUS);
  assign hit_data = (paddr == `TWS_OFF_DATA);
  assign wr_ctrl  = acc & pwrite & hit_ctrl;
  assign wr_data  = acc & pwrite & hit_data;
  assign go       = wr_ctrl & pwdata[`TWS_CR_FLAG] & flag_r;
  assign last_bit = (bit_r == 4'd8);
  assign tx_state = (code_r == `TWS_ST_START) | (code_r == `TWS_ST_RSTART) |
                    (code_r == `TWS_ST_AW_ACK) | (code_r == `TWS_ST_AW_NACK) |
                    (code_r == `TWS_ST_TX_ACK) | (code_r == `TWS_ST_TX_NACK);
  assign rx_state = (code_r == `TWS_ST_AR_ACK) | (code_r == `TWS_ST_RX_ACK);
  assign ctrl_rd  = {flag_r, acken_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};

  assign pready  = 1'b1;
  assign pslverr = acc & ~(hit_ctrl | hit_stat | hit_data);
  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign scl_oe  = scl_drv_r;
  assign sda_oe  = sda_drv_r;

  // Pin synchronisers and bus-free tracking
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      sda_prev_r <= 1'b1;
      busy_r     <= 1'b0;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      sda_prev_r <= sda_s;
      if (scl_s && sda_prev_r && !sda_s)
        busy_r <= 1'b1;
      else if (scl_s && !sda_prev_r && sda_s)
        busy_r <= 1'b0;
    end
  end

  // Quarter-bit enable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= 8'h00;
    else if (tick)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end

  // Read data captured in the setup phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (hit_ctrl)
        prdata <= {24'h00_0000, ctrl_rd};
      else if (hit_stat)
        prdata <= {24'h00_0000, code_r[7:3], 3'b000};
      else if (hit_data)
        prdata <= {24'h00_0000, data_r};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Registers and bus sequencer; later assignments win, so hardware sets
  // override a software clear in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_r    <= 1'b0;
      acken_r   <= 1'b0;
      sta_r     <= 1'b0;
      sto_r     <= 1'b0;
      wcol_r    <= 1'b0;
      en_r      <= 1'b0;
      ie_r      <= 1'b0;
      data_r    <= `TWS_DATA_RST;
      code_r    <= `TWS_ST_IDLE;
      sh_r      <= 8'h00;
      st_r      <= S_IDLE;
      ph_r      <= 2'd0;
      bit_r     <= 4'd0;
      rx_r      <= 1'b0;
      addr_r    <= 1'b0;
      rnw_r     <= 1'b0;
      ack_out_r <= 1'b0;
      ack_in_r  <= 1'b1;
      owner_r   <= 1'b0;
      scl_drv_r <= 1'b0;
      sda_drv_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        acken_r <= pwdata[`TWS_CR_ACKEN];
        sta_r   <= pwdata[`TWS_CR_STA];
        sto_r   <= pwdata[`TWS_CR_STO];
        en_r    <= pwdata[`TWS_CR_EN];
        ie_r    <= pwdata[`TWS_CR_IE];
        if (pwdata[`TWS_CR_FLAG])
          flag_r <= 1'b0;
      end
      if (wr_data)
      begin
        if (flag_r)
        begin
          data_r <= pwdata[7:0];
          wcol_r <= 1'b0;
        end
        else
          wcol_r <= 1'b1;
      end

      if (!en_r)
      begin
        st_r      <= S_IDLE;
        owner_r   <= 1'b0;
        scl_drv_r <= 1'b0;
        sda_drv_r <= 1'b0;
      end
      else
      begin
        case (st_r)
          S_IDLE:
          begin
            if (sta_r && !busy_r && !flag_r && tick)
            begin
              st_r <= S_STA;
              ph_r <= 2'd0;
            end
          end

          S_STA:
          begin
            if (tick)
            begin
              case (ph_r)
                2'd0:
                begin
                  sda_drv_r <= 1'b0;
                  ph_r      <= 2'd1;
                end
                2'd1:
                begin
                  scl_drv_r <= 1'b0;
                  if (scl_s)
                    ph_r <= 2'd2;
                end
                2'd2:
                begin
                  sda_drv_r <= 1'b1;
                  ph_r      <= 2'd3;
                end
                default:
                begin
                  scl_drv_r <= 1'b1;
                  code_r    <= owner_r ? `TWS_ST_RSTART : `TWS_ST_START;
                  owner_r   <= 1'b1;
                  flag_r    <= 1'b1;
                  st_r      <= S_HOLD;
                end
              endcase
            end
          end

          S_HOLD:
          begin
            if (go)
            begin
              ph_r  <= 2'd0;
              bit_r <= 4'd0;
              if (!owner_r)
              begin
                st_r   <= S_IDLE;
                code_r <= `TWS_ST_IDLE;
              end
              else if (pwdata[`TWS_CR_STO])
                st_r <= S_STP;
              else if (pwdata[`TWS_CR_STA])
                st_r <= S_STA;
              else if (tx_state)
              begin
                st_r   <= S_BIT;
                rx_r   <= 1'b0;
                sh_r   <= data_r;
                addr_r <= (code_r == `TWS_ST_START) | (code_r == `TWS_ST_RSTART);
                if ((code_r == `TWS_ST_START) || (code_r == `TWS_ST_RSTART))
                  rnw_r <= data_r[0];
              end
              else if (rx_state)
              begin
                st_r      <= S_BIT;
                rx_r      <= 1'b1;
                addr_r    <= 1'b0;
                ack_out_r <= pwdata[`TWS_CR_ACKEN];
              end
            end
          end

          S_BIT:
          begin
            if (tick)
            begin
              case (ph_r)
                2'd0:
                begin
                  if (rx_r)
                    sda_drv_r <= last_bit & ack_out_r;
                  else
                    sda_drv_r <= ~last_bit & ~sh_r[7];
                  ph_r <= 2'd1;
                end
                2'd1:
                begin
                  scl_drv_r <= 1'b0;
                  if (scl_s)
                    ph_r <= 2'd2;
                end
                2'd2:
                begin
                  if (!rx_r && !last_bit && sh_r[7] && !sda_s)
                  begin
                    sda_drv_r <= 1'b0;
                    scl_drv_r <= 1'b0;
                    owner_r   <= 1'b0;
                    code_r    <= `TWS_ST_LOST;
                    flag_r    <= 1'b1;
                    st_r      <= S_HOLD;
                  end
                  else
                  begin
                    if (last_bit)
                      ack_in_r <= sda_s;
                    else
                      sh_r <= {sh_r[6:0], sda_s};
                    ph_r <= 2'd3;
                  end
                end
                default:
                begin
                  scl_drv_r <= 1'b1;
                  ph_r      <= 2'd0;
                  if (!last_bit)
                    bit_r <= bit_r + 4'd1;
                  else
                  begin
                    flag_r <= 1'b1;
                    st_r   <= S_HOLD;
                    if (rx_r)
                    begin
                      data_r <= sh_r;
                      code_r <= ack_out_r ? `TWS_ST_RX_ACK : `TWS_ST_RX_NACK;
                    end
                    else if (addr_r && rnw_r)
                      code_r <= ack_in_r ? `TWS_ST_AR_NACK : `TWS_ST_AR_ACK;
                    else if (addr_r)
                      code_r <= ack_in_r ? `TWS_ST_AW_NACK : `TWS_ST_AW_ACK;
                    else
                      code_r <= ack_in_r ? `TWS_ST_TX_NACK : `TWS_ST_TX_ACK;
                  end
                end
              endcase
            end
          end

          default:
          begin
            if (tick)
            begin
              case (ph_r)
                2'd0:
                begin
                  sda_drv_r <= 1'b1;
                  ph_r      <= 2'd1;
                end
                2'd1:
                begin
                  scl_drv_r <= 1'b0;
                  if (scl_s)
                    ph_r <= 2'd2;
                end
                2'd2:
                begin
                  sda_drv_r <= 1'b0;
                  ph_r      <= 2'd3;
                end
                default:
                begin
                  sto_r   <= 1'b0;
                  owner_r <= 1'b0;
                  code_r  <= `TWS_ST_IDLE;
                  st_r    <= S_IDLE;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

endmodule // tws_master

`default_nettype wire

// [verif/tws_master_sva.sv]
/*
  Assertion checker for tws_master, bound to its ports.
  Assumes one pclk domain and the register map header.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tws_map.vh"
module tws_master_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_i,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_oe
);
  wire logic  ctl_rd = psel && !penable && !pwrite && paddr == `TWS_OFF_CTRL;
  wire logic  st_rd  = psel && !penable && !pwrite && paddr == `TWS_OFF_STATUS;
  logic [7:0] sto_cnt_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the last stop request write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sto_cnt_r <= 8'hff;
    else if (psel && penable && pwrite && paddr == `TWS_OFF_CTRL && pwdata[4])
      sto_cnt_r <= 8'h00;
    else if (sto_cnt_r != 8'hff)
      sto_cnt_r <= sto_cnt_r + 8'h01;
  start_free_a: assert property ($rose(sda_oe) && !scl_oe |-> $past(sda_i) && scl_i)
    else $error("start driven on a busy bus");
  stop_setup_a: assert property ($fell(sda_oe) && !scl_oe |-> !$past(scl_oe) && !$past(scl_oe, 2))
    else $error("data released without clock high first");
  stat_low_a: assert property (st_rd |=> prdata[2:0] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("status low bits not zero");
  stat_code_a: assert property (st_rd |=> prdata[7:0] inside {8'h08, 8'h10, 8'h18, 8'h20,
    8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'h50, 8'h58, 8'hf8})
    else $error("status code outside the table");
  stop_clear_a: assert property (ctl_rd && sto_cnt_r > 8'h3c |=> !prdata[4])
    else $error("stop request not cleared");
  clk_hold_a: assert property (ctl_rd ##1 (prdata[7] && scl_oe) |-> scl_oe [*4])
    else $error("clock released while flag set");
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("access phase not ready");
  bad_addr_a: assert property (psel && penable |-> pslverr == !(paddr inside
    {`TWS_OFF_CTRL, `TWS_OFF_STATUS, `TWS_OFF_DATA}))
    else $error("error response wrong");
  start_seen_c: cover property ($rose(sda_oe) && !scl_oe);
  bad_addr_c: cover property (psel && penable && pslverr);
  lost_code_c: cover property (st_rd ##1 prdata[7:0] == 8'h38);
endmodule // tws_master_sva
bind tws_master tws_master_sva tws_master_sva_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .scl_i, .scl_oe, .sda_i, .sda_oe
);
`default_nettype wire

// [verif/tws_master_test.sv]
/*
  Self-checking bench for tws_master: APB tasks, one task per scenario,
  a slave model and a rival pull-down. Assumes the register map header.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tws_map.vh"
module tws_master_test;
  logic        pclk, presetn, psel, penable, pwrite, perr, ack_en, rv_pull;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata;
  logic [7:0]  tx_byte;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl_o, sda_o, scl_oe, sda_oe, sda_pull;
  wire  [7:0]  got;
  wire         scl_bus = !scl_oe;
  wire         sda_bus = !(sda_oe || sda_pull || rv_pull);
  int          fails = 0;
  int          total_checks = 0;
  tws_master tws_master_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_i(scl_bus), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  tws_slave_model tws_slave_model_inst (
    .scl(scl_bus), .sda(sda_bus), .ack_en(ack_en), .tx_byte(tx_byte),
    .sda_pull(sda_pull), .got(got)
  );
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdata = prdata;
    perr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask
  task automatic poll(input int b, input logic v);
    int i;
    i = 0;
    do
    begin
      apb(1'b0, `TWS_OFF_CTRL, 8'h00);
      i++;
    end
    while (rdata[b] !== v && i < 400);
    chk({31'h0, rdata[b]}, {31'h0, v});
  endtask
  task automatic go(input logic [7:0] c, input logic [7:0] e);
    apb(1'b1, `TWS_OFF_CTRL, c);
    poll(7, 1'b1);
    rdc(`TWS_OFF_STATUS, {24'h000000, e});
  endtask
  task automatic stop_bus;
    apb(1'b1, `TWS_OFF_CTRL, 8'h94);
    poll(4, 1'b0);
    rdc(`TWS_OFF_STATUS, 32'h000000f8);
    chk({28'h0, scl_o, sda_o, scl_oe, sda_oe}, 32'h0);
  endtask
  task automatic reg_scene;
    rdc(`TWS_OFF_CTRL, 32'h00000000);
    rdc(`TWS_OFF_STATUS, 32'h000000f8);
    rdc(`TWS_OFF_DATA, 32'h000000ff);
    apb(1'b1, `TWS_OFF_DATA, 8'h55);
    rdc(`TWS_OFF_CTRL, 32'h00000008);
    rdc(`TWS_OFF_DATA, 32'h000000ff);
    apb(1'b0, 12'h00c, 8'h00);
    chk({31'h0, perr}, 32'h1);
  endtask
  task automatic tx_scene;
    go(8'ha4, `TWS_ST_START);
    apb(1'b1, `TWS_OFF_DATA, 8'ha0);
    go(8'h84, `TWS_ST_AW_ACK);
    apb(1'b1, `TWS_OFF_DATA, 8'h3c);
    go(8'h84, `TWS_ST_TX_ACK);
    chk({24'h0, got}, 32'h3c);
    ack_en = 1'b0;
    apb(1'b1, `TWS_OFF_DATA, 8'hc3);
    go(8'h84, `TWS_ST_TX_NACK);
    chk({24'h0, got}, 32'hc3);
    ack_en = 1'b1;
    go(8'ha4, `TWS_ST_RSTART);
  endtask
  task automatic rx_scene;
    apb(1'b1, `TWS_OFF_DATA, 8'ha1);
    go(8'h84, `TWS_ST_AR_ACK);
    go(8'hc4, `TWS_ST_RX_ACK);
    rdc(`TWS_OFF_DATA, 32'h96);
    go(8'h84, `TWS_ST_RX_NACK);
    rdc(`TWS_OFF_DATA, 32'h96);
    go(8'hb4, `TWS_ST_START);
    apb(1'b0, `TWS_OFF_CTRL, 8'h00);
    chk(rdata & 32'h10, 32'h0);
    ack_en = 1'b0;
    apb(1'b1, `TWS_OFF_DATA, 8'ha1);
    go(8'h84, `TWS_ST_AR_NACK);
    ack_en = 1'b1;
    stop_bus;
  endtask
  task automatic lost_scene;
    go(8'ha4, `TWS_ST_START);
    rv_pull <= 1'b1;
    apb(1'b1, `TWS_OFF_DATA, 8'ha0);
    go(8'h84, `TWS_ST_LOST);
    chk({30'h0, scl_oe, sda_oe}, 32'h0);
    apb(1'b1, `TWS_OFF_CTRL, 8'h84);
    rdc(`TWS_OFF_STATUS, 32'hf8);
    rv_pull <= 1'b0;
    go(8'ha4, `TWS_ST_START);
    rv_pull <= 1'b1;
    apb(1'b1, `TWS_OFF_DATA, 8'ha0);
    go(8'h84, `TWS_ST_LOST);
    apb(1'b1, `TWS_OFF_CTRL, 8'ha4);
    repeat (40) @(posedge pclk);
    chk({31'h0, sda_oe}, 32'h0);
    rv_pull <= 1'b0;
    poll(7, 1'b1);
    rdc(`TWS_OFF_STATUS, 32'h08);
    stop_bus;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    #400000;
    fails++;
    tally_and_finish;
  end
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    ack_en  = 1'b1;
    rv_pull = 1'b0;
    tx_byte = 8'h96;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reg_scene;
    tx_scene;
    rx_scene;
    lost_scene;
    tally_and_finish;
  end
endmodule // tws_master_test
`default_nettype wire

// [verif/tws_slave_model.sv]
/*
  Behavioural slave on the two-wire bus: acknowledges per ack_en and
  sends tx_byte while read. Assumes pulled-up lines resolved outside.
*/
`timescale 1ns/1ns
`default_nettype none
module tws_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  input  wire logic [7:0] tx_byte,
  output var  logic       sda_pull,
  output var  logic [7:0] got
);
  logic [7:0] sh_r;
  logic       rd_r, adr_r, drv_r;
  int         n;
  initial
  begin
    sda_pull = 1'b0;
    got      = 8'h00;
    drv_r    = 1'b0;
    n        = 0;
  end
  always @(negedge sda)
    if (scl)
    begin
      n     = 0;
      adr_r = 1'b1;
      drv_r = 1'b0;
    end
  always @(posedge scl)
  begin
    sh_r = {sh_r[6:0], sda};
    n    = n + 1;
  end
  always @(negedge scl)
  begin
    if (n == 9)
    begin
      drv_r = rd_r && !sh_r[0];
      adr_r = 1'b0;
      n     = 0;
    end
    if (n < 8)
      sda_pull = drv_r && !tx_byte[7 - n];
    else if (n == 8)
    begin
      got = sh_r;
      if (adr_r)
        rd_r = sh_r[0];
      sda_pull = ack_en && (adr_r || !rd_r);
    end
  end
endmodule // tws_slave_model
`default_nettype wire
